// [bus_cycle_defs.svh]
`ifndef BUS_CYCLE_DEFS_SVH
`define BUS_CYCLE_DEFS_SVH

// Register address and reset value
`define BCC_ADDR        8'h9D
`define BCC_RESET       8'hEB
// Field positions
`define BCC_PFQ_BIT     7
`define BCC_BC_BIT      6
`define BCC_WR_HI       5
`define BCC_WR_LO       4
`define BCC_RD_HI       3
`define BCC_RD_LO       2
`define BCC_CW_HI       1
`define BCC_CW_LO       0
// Cycle length bases and constant-read minimum in clocks
`define DATA_BASE_CLK   3'h4
`define CODE_BASE_CLK   3'h3
`define CONST_MIN_CLK   3'h4

`endif

// [bus_cycle_pkg.sv]
package bus_cycle_pkg;

	typedef enum logic [2:0] {
		KIND_CODE  = 3'h1,
		KIND_CONST = 3'h2,
		KIND_DATA  = 3'h4
	} cycle_kind_t;

	typedef struct packed {
		logic       start;
		logic       is_code;
		logic       is_const;
		logic       is_read;
		logic       is_write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cycle_req_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h1,
		ST_ACTIVE = 3'h2,
		ST_STALL  = 3'h4
	} cycle_state_t;

endpackage : bus_cycle_pkg

// [bus_cycle_wait_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bus_cycle_defs.svh"

module bus_cycle_wait_control (
	// Clock and reset
	input  wire logic                      clk_sys_i,
	input  wire logic                      rst_n_i,
	// Special-function register port
	input  wire logic [7:0]                sfr_addr_i,
	input  wire logic                      sfr_wr_i,
	input  wire logic [7:0]                sfr_wdata_i,
	output logic      [7:0]                sfr_rdata_o,
	output logic                           sfr_hit_o,
	// Cycle request from the core
	input  wire bus_cycle_pkg::cycle_req_t req_i,
	input  wire logic                      abort_i,
	input  wire logic                      stall_i,
	input  wire logic                      pfq_speculative_i,
	input  wire logic                      bc_hit_i,
	// Bus side
	input  wire logic [15:0]               ad_in_i,
	output logic      [15:0]               ad_out_o,
	output logic      [15:0]               ad_oe_o,
	output logic                           code_fetch_strobe_o,
	output logic                           rd_strobe_o,
	output logic                           wr_strobe_o,
	// Results to the core
	output logic                           busy_o,
	output logic                           done_o,
	output logic      [15:0]               rdata_o,
	output logic                           prefetch_queue_enable_o,
	output logic                           branch_cache_enable_o,
	output logic                           fetch_allowed_o,
	output logic                           bc_hit_use_o
);

	// ==========================================================
	// Control register
	logic [7:0] bus_cycle_control;
	logic [7:0] next_bus_cycle_control;

	always_comb begin
		next_bus_cycle_control = bus_cycle_control;
		if (sfr_wr_i && sfr_addr_i == `BCC_ADDR) begin
			next_bus_cycle_control = sfr_wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_cycle_control <= `BCC_RESET;
		end else begin
			bus_cycle_control <= next_bus_cycle_control;
		end
	end

	assign sfr_hit_o               = (sfr_addr_i == `BCC_ADDR);
	assign sfr_rdata_o             = sfr_hit_o ? bus_cycle_control : 8'h00;
	assign prefetch_queue_enable_o = bus_cycle_control[`BCC_PFQ_BIT];
	assign branch_cache_enable_o   = bus_cycle_control[`BCC_BC_BIT];
	// Speculative fetches gated when the queue is off; cache hits dropped when off
	assign fetch_allowed_o = prefetch_queue_enable_o | ~pfq_speculative_i;
	assign bc_hit_use_o    = branch_cache_enable_o & bc_hit_i;

	// ==========================================================
	// Cycle length, chosen from cycle type and its control field, never the address
	function automatic logic [2:0] cycle_len(input logic [7:0] ctl, input bus_cycle_pkg::cycle_req_t r);
		logic [2:0] len;
		len = 3'h0;
		if (r.is_code || r.is_const) begin
			len = `CODE_BASE_CLK + {1'b0, ctl[`BCC_CW_HI:`BCC_CW_LO]};
			if (r.is_const && len < `CONST_MIN_CLK) begin
				len = `CONST_MIN_CLK;
			end
		end else if (r.is_read) begin
			len = `DATA_BASE_CLK + {1'b0, ctl[`BCC_RD_HI:`BCC_RD_LO]};
		end else begin
			len = `DATA_BASE_CLK + {1'b0, ctl[`BCC_WR_HI:`BCC_WR_LO]};
		end
		return len;
	endfunction : cycle_len

	// ==========================================================
	// Cycle sequencer
	bus_cycle_pkg::cycle_state_t state;
	bus_cycle_pkg::cycle_state_t next_state;
	logic [2:0]  remain;
	logic [2:0]  next_remain;
	logic        cur_code;
	logic        next_cur_code;
	logic        cur_read;
	logic        next_cur_read;
	logic        cur_write;
	logic        next_cur_write;
	logic [15:0] cur_addr;
	logic [15:0] next_cur_addr;
	logic [7:0]  cur_wdata;
	logic [7:0]  next_cur_wdata;
	logic [15:0] rdata;
	logic [15:0] next_rdata;
	logic        done;
	logic        next_done;
	logic        last;

	assign last = (remain == 3'h1);

	always_comb begin
		next_state     = state;
		next_remain    = remain;
		next_cur_code  = cur_code;
		next_cur_read  = cur_read;
		next_cur_write = cur_write;
		next_cur_addr  = cur_addr;
		next_cur_wdata = cur_wdata;
		next_rdata     = rdata;
		next_done      = 1'b0;
		case (state)
			bus_cycle_pkg::ST_IDLE: begin
				if (req_i.start) begin
					// Length latched at start so a later write cannot reshape it
					next_remain    = cycle_len(bus_cycle_control, req_i);
					next_cur_code  = req_i.is_code | req_i.is_const;
					next_cur_read  = req_i.is_read;
					next_cur_write = req_i.is_write;
					next_cur_addr  = req_i.addr;
					next_cur_wdata = req_i.wdata;
					next_state     = bus_cycle_pkg::ST_ACTIVE;
				end
			end
			bus_cycle_pkg::ST_ACTIVE: begin
				if (cur_code && abort_i) begin
					next_state = bus_cycle_pkg::ST_IDLE;
				end else if (last && cur_code && stall_i) begin
					next_state = bus_cycle_pkg::ST_STALL;
				end else if (last) begin
					// Code takes all 16 lines, data only the low byte
					next_rdata = cur_code ? ad_in_i : {8'h00, ad_in_i[7:0]};
					next_done  = 1'b1;
					next_state = bus_cycle_pkg::ST_IDLE;
				end else begin
					next_remain = remain - 3'h1;
				end
			end
			bus_cycle_pkg::ST_STALL: begin
				if (abort_i) begin
					next_state = bus_cycle_pkg::ST_IDLE;
				end else if (!stall_i) begin
					next_rdata = ad_in_i;
					next_done  = 1'b1;
					next_state = bus_cycle_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = bus_cycle_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state     <= bus_cycle_pkg::ST_IDLE;
			remain    <= 3'h0;
			cur_code  <= 1'b0;
			cur_read  <= 1'b0;
			cur_write <= 1'b0;
			cur_addr  <= 16'h0000;
			cur_wdata <= 8'h00;
			rdata     <= 16'h0000;
			done      <= 1'b0;
		end else begin
			state     <= next_state;
			remain    <= next_remain;
			cur_code  <= next_cur_code;
			cur_read  <= next_cur_read;
			cur_write <= next_cur_write;
			cur_addr  <= next_cur_addr;
			cur_wdata <= next_cur_wdata;
			rdata     <= next_rdata;
			done      <= next_done;
		end
	end

	// ==========================================================
	// Bus pins
	logic active;
	assign active              = (state != bus_cycle_pkg::ST_IDLE);
	assign busy_o              = active;
	assign done_o              = done;
	assign rdata_o             = rdata;
	assign code_fetch_strobe_o = active & cur_code;
	assign rd_strobe_o         = active & cur_read & ~cur_code;
	assign wr_strobe_o         = active & cur_write & ~cur_code;
	// Write data drives only the low byte
	assign ad_out_o = (active && cur_write && !cur_code) ? {8'h00, cur_wdata} : cur_addr;
	assign ad_oe_o  = (active && cur_write && !cur_code) ? 16'h00FF : 16'h0000;

	// ==========================================================
	// Checks
	property p_reset_value;
		@(posedge clk_sys_i) $rose(rst_n_i)
		|-> bus_cycle_control == `BCC_RESET && prefetch_queue_enable_o && branch_cache_enable_o;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad reset value");

	property p_pfq_bit;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(sfr_wr_i && sfr_addr_i == `BCC_ADDR)
		|=> prefetch_queue_enable_o == $past(sfr_wdata_i[7]) && branch_cache_enable_o == $past(sfr_wdata_i[6]);
	endproperty
	a_pfq_bit: assert property (p_pfq_bit) else $error("enable bits mismatch");

	property p_write_takes;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(sfr_wr_i && sfr_addr_i == 8'h9D) |=> bus_cycle_control == $past(sfr_wdata_i);
	endproperty
	a_write_takes: assert property (p_write_takes) else $error("register write lost");

	property p_read_len;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state == bus_cycle_pkg::ST_IDLE && req_i.start && req_i.is_read && !req_i.is_code && !req_i.is_const)
		|=> remain == 3'h4 + {1'b0, $past(bus_cycle_control[3:2])};
	endproperty
	a_read_len: assert property (p_read_len) else $error("read length wrong");

	property p_write_len;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state == bus_cycle_pkg::ST_IDLE && req_i.start && req_i.is_write && !req_i.is_read
		 && !req_i.is_code && !req_i.is_const)
		|=> remain == 3'h4 + {1'b0, $past(bus_cycle_control[5:4])};
	endproperty
	a_write_len: assert property (p_write_len) else $error("write length wrong");

	property p_const_min;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state == bus_cycle_pkg::ST_IDLE && req_i.start && req_i.is_const) |=> remain >= 3'h4;
	endproperty
	a_const_min: assert property (p_const_min) else $error("constant read too short");

	property p_data_no_stall;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!cur_code |-> state != bus_cycle_pkg::ST_STALL;
	endproperty
	a_data_no_stall: assert property (p_data_no_stall) else $error("data cycle stalled");

	property p_stall_holds;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state == bus_cycle_pkg::ST_STALL && stall_i && !abort_i) |=> state == bus_cycle_pkg::ST_STALL && !done;
	endproperty
	a_stall_holds: assert property (p_stall_holds) else $error("stall not honoured");

	property p_data_low_byte;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(done && !$past(cur_code)) |-> rdata_o[15:8] == 8'h00;
	endproperty
	a_data_low_byte: assert property (p_data_low_byte) else $error("data read wider than byte");

	// Busy-cycle counter, so the data checks measure a cycle instead of trusting remain
	logic [3:0] span;
	logic [3:0] next_span;
	logic [2:0] span_len;
	logic [2:0] next_span_len;

	always_comb begin
		next_span     = span;
		next_span_len = span_len;
		if (state == bus_cycle_pkg::ST_IDLE && req_i.start) begin
			next_span     = 4'h0;
			next_span_len = cycle_len(bus_cycle_control, req_i);
		end else if (active && span != 4'hF) begin
			next_span = span + 4'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			span     <= 4'h0;
			span_len <= 3'h0;
		end else begin
			span     <= next_span;
			span_len <= next_span_len;
		end
	end

	property p_data_span;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(done && !$past(cur_code)) |-> span == {1'b0, span_len};
	endproperty
	a_data_span: assert property (p_data_span) else $error("data cycle length not as programmed");

	property p_len_frozen;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state == bus_cycle_pkg::ST_ACTIVE && !last && !(cur_code && abort_i))
		|=> state == bus_cycle_pkg::ST_ACTIVE && remain == $past(remain) - 3'h1;
	endproperty
	a_len_frozen: assert property (p_len_frozen) else $error("cycle length changed in flight");

	property p_abort_ends;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state != bus_cycle_pkg::ST_IDLE && cur_code && abort_i)
		|=> state == bus_cycle_pkg::ST_IDLE && !done;
	endproperty
	a_abort_ends: assert property (p_abort_ends) else $error("aborted fetch still completed");

endmodule : bus_cycle_wait_control
`default_nettype wire

// [flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far-side memory: word derived from address
module flash_model (
	// Bus from the block
	input  wire logic        clk_sys_i,
	input  wire logic        code_fetch_strobe_i,
	input  wire logic        rd_strobe_i,
	input  wire logic [15:0] ad_out_i,
	// Data back to the block
	output logic      [15:0] ad_in_o
);
	initial ad_in_o = 16'h5A5A;
	// Deselected lines toggle so a mistimed sample never sees old data
	always @(posedge clk_sys_i) begin
		if (code_fetch_strobe_i || rd_strobe_i)
			ad_in_o <= ad_out_i ^ 16'hA55A;
		else
			ad_in_o <= ~ad_in_o;
	end
endmodule : flash_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, shadow;
	logic sfr_wr = 1'b0, abort = 1'b0, stall = 1'b0, spec = 1'b0, bch = 1'b0;
	bus_cycle_pkg::cycle_req_t req = '0;
	logic [15:0] ad_in, ad_out, ad_oe, rdata;
	logic hit, cfs, rds, wrs, busy, done, pqe, bce, fa, bhu;
	int n_errors = 0;
	int n_tests = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	bus_cycle_wait_control i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata),
		.sfr_rdata_o(sfr_rdata), .sfr_hit_o(hit), .req_i(req), .abort_i(abort),
		.stall_i(stall), .pfq_speculative_i(spec), .bc_hit_i(bch), .ad_in_i(ad_in),
		.ad_out_o(ad_out), .ad_oe_o(ad_oe), .code_fetch_strobe_o(cfs),
		.rd_strobe_o(rds), .wr_strobe_o(wrs), .busy_o(busy), .done_o(done),
		.rdata_o(rdata), .prefetch_queue_enable_o(pqe), .branch_cache_enable_o(bce),
		.fetch_allowed_o(fa), .bc_hit_use_o(bhu));

	flash_model i_mem (.clk_sys_i(clk_sys_i), .code_fetch_strobe_i(cfs),
		.rd_strobe_i(rds), .ad_out_i(ad_out), .ad_in_o(ad_in));

	// ==========================================
	// Tasks
	task automatic stop_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk_sys_i);
		sfr_wr = 1'b0;
		if (a == 8'h9D)
			shadow = d;
	endtask : sfr_put

	task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys_i);
		sfr_addr = a;
		#1;
		chk({8'h00, sfr_rdata}, {8'h00, exp});
		chk(16'(hit), 16'(a == 8'h9D));
	endtask : sfr_chk

	// Kind: 0 code, 1 constant, 2 data read, 3 data write
	function automatic int clen(input int k);
		case (k)
			0: return 3 + int'(shadow[1:0]);
			1: return (shadow[1:0] == 2'b00) ? 4 : 3 + int'(shadow[1:0]);
			2: return 4 + int'(shadow[3:2]);
			default: return 4 + int'(shadow[5:4]);
		endcase
	endfunction : clen

	task automatic cyc(input int k, input logic [15:0] a, input logic st, input logic ab, input logic mw);
		int n;
		int exp;
		exp = clen(k);
		n = 0;
		@(negedge clk_sys_i);
		req = '{start: 1'b1, is_code: k == 0, is_const: k == 1, is_read: k == 2, is_write: k == 3,
			addr: a, wdata: a[15:8]};
		stall = st;
		sfr_addr = 8'h9D;
		sfr_wdata = 8'hFF;
		@(negedge clk_sys_i);
		req.start = 1'b0;
		chk({13'h0, cfs, rds, wrs}, 16'h1 << ((k < 2) ? 2 : 3 - k));
		chk(ad_oe, (k == 3) ? 16'h00FF : 16'h0000);
		chk((k == 3) ? {8'h00, ad_out[7:0]} : ad_out, (k == 3) ? {8'h00, a[15:8]} : a);
		while (busy === 1'b1 && n < 30) begin
			n++;
			sfr_wr = mw && n == 1;
			abort = ab && n >= 2;
			stall = st && n <= exp + 1;
			@(negedge clk_sys_i);
		end
		chk(16'(done), 16'(!ab));
		// Abort is first seen at the second edge; stall stays up one edge past the last count
		if (ab)
			chk(16'(n), 16'h2);
		else if (st && k < 2)
			chk(16'(n), 16'(exp + 2));
		else
			chk(16'(n), 16'(exp));
		if (!ab && k < 2)
			chk(rdata, a ^ 16'hA55A);
		if (!ab && k == 2)
			chk(rdata, {8'h00, a[7:0] ^ 8'h5A});
		abort = 1'b0;
		stall = 1'b0;
		if (mw)
			shadow = 8'hFF;
	endtask : cyc

	// ==========================================
	// Sequence
	initial begin
		repeat (4) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		shadow = 8'hEB;
		sfr_chk(8'h9D, 8'hEB);
		chk({14'h0, pqe, bce}, 16'h3);
		sfr_put(8'h9C, 8'h00);
		sfr_chk(8'h9C, 8'h00);
		sfr_chk(8'h9D, 8'hEB);
		for (int c = 0; c < 5; c++) begin
			// Field code repeated in all three fields; C0 is the slow-clock setting
			if (c > 0)
				sfr_put(8'h9D, 8'hC0 | 8'((c - 1) * 8'h15));
			for (int k = 0; k < 4; k++) begin
				cyc(k, 16'h0042, 1'b0, 1'b0, 1'b0);
				cyc(k, 16'hF0C3, 1'b0, 1'b0, 1'b0);
			end
		end
		// Firmware settings for full speed: five clocks everywhere, then four
		sfr_put(8'h9D, 8'hD6);
		for (int k = 0; k < 4; k++)
			cyc(k, 16'h3C96, 1'b0, 1'b0, 1'b0);
		sfr_put(8'h9D, 8'hC1);
		for (int k = 0; k < 4; k++)
			cyc(k, 16'h3C96, 1'b0, 1'b0, 1'b0);
		sfr_put(8'h9D, 8'h3F);
		spec = 1'b1;
		bch = 1'b1;
		#1;
		chk({12'h0, pqe, bce, fa, bhu}, 16'h0);
		sfr_put(8'h9D, 8'hC0);
		#1;
		chk({12'h0, pqe, bce, fa, bhu}, 16'hF);
		sfr_put(8'h9D, 8'hEB);
		cyc(0, 16'h1357, 1'b1, 1'b0, 1'b0);
		cyc(2, 16'h1357, 1'b1, 1'b0, 1'b0);
		cyc(0, 16'h2468, 1'b0, 1'b1, 1'b0);
		sfr_put(8'h9D, 8'hC0);
		cyc(2, 16'h0A0B, 1'b0, 1'b0, 1'b1);
		cyc(2, 16'h0A0B, 1'b0, 1'b0, 1'b0);
		sfr_chk(8'h9D, 8'hFF);
		// Queue off, cache on, then a second reset in mid-run must restore both
		sfr_put(8'h9D, 8'h70);
		#1;
		chk({12'h0, pqe, bce, fa, bhu}, 16'h5);
		@(negedge clk_sys_i);
		rst_n_i = 1'b0;
		#1;
		chk({12'h0, pqe, bce, busy, done}, 16'hC);
		repeat (2) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		shadow = 8'hEB;
		sfr_chk(8'h9D, 8'hEB);
		cyc(1, 16'h0C0D, 1'b0, 1'b0, 1'b0);
		stop_test();
	end

	// Whole run is a few hundred cycles
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end
endmodule : testbench
`default_nettype wire
